// ### rtl/diwc_pkg.sv
// Behaviour
// R1 - field 1: pixel output stops once the image pixel counter equals the image width
// R2 - field 1: line output stops once the image line counter passes the image height
// R3 - field 1 image height is a 12-bit field, bits 27:16, reset zero
// R4 - field 1 width in bits 11:0; its lsb is zero except in raw mode
// R5 - reserved bits of both window registers read zero and ignore writes
// R6 - field 2 line counter loads one at blanking end line plus vertical offset
// R7 - with negative vertical offset it loads at blanking end line minus offset
// R8 - field 2 image starts on the line where the line counter is one
// R9 - software keeps a negative vertical offset no larger than the blanking end line
// R10 - software keeps the field 2 image clear of the other field's image
// R11 - image pixel counter clears to zero at each line image start
// R12 - field 2 pixels start where the frame pixel counter equals the offset
// R13 - negative horizontal offset starts the line at frame width minus offset
// R14 - bit 31 of field 2 offset enables negative vertical offset, not in raw
// R15 - bit 15 of field 2 offset enables negative horizontal offset, not in raw
// R16 - field 2 vertical offset is a 12-bit field, bits 27:16, reset zero
// R17 - field 2 horizontal offset in bits 11:0; its lsb is zero except in raw
// R18 - counters and comparisons advance once per pixel enable on mclk
package diwc_pkg;

  localparam int ADDR_W = 8;
  localparam int REG_W  = 32;
  localparam int CNT_W  = 12;
  localparam int PIX_W  = 10;
  localparam int FIFO_DEPTH = 32;

  // register map
  localparam logic [ADDR_W-1:0] REG_F1_SIZE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_F2_OFF  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_TIMING  = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h10;

  // field layout; high and low fields shared by the window registers, the rest are per register
  localparam int HI_LSB   = 16;
  localparam int LO_LSB   = 0;
  localparam int NV_BIT   = 31;
  localparam int NH_BIT   = 15;
  localparam int RUN_BIT  = 31;
  localparam int MODE_LSB = 0;
  localparam int MODE_W   = 2;

  // writable bit masks, reserved positions are zero
  localparam logic [REG_W-1:0] F1_SIZE_MASK = 32'h0fff_0fff;
  localparam logic [REG_W-1:0] F2_OFF_MASK  = 32'h8fff_8fff;
  localparam logic [REG_W-1:0] CTRL_MASK    = 32'h0000_0003;
  localparam logic [REG_W-1:0] TIMING_MASK  = 32'h0fff_0fff;
  localparam logic [REG_W-1:0] REG_RESET    = 32'h0000_0000;

  localparam logic [PIX_W-1:0] BLANK_VALUE = 10'h040;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE     = 12'h001;
  localparam logic [CNT_W-1:0] CNT_MAX     = 12'hfff;

  typedef enum logic [1:0]
  {
    DIWC_BT656 = 2'b00,
    DIWC_YC    = 2'b01,
    DIWC_RAW   = 2'b10
  } diwc_mode_e;

endpackage : diwc_pkg

// ### rtl/diwc_stream_if.sv
interface diwc_stream_if #(parameter int W = 10);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : diwc_stream_if

// ### rtl/diwc_fifo.sv
module diwc_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 32
) (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output      logic         inReady,
  diwc_stream_if.src        outPort
);
  import diwc_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wrPtr;
  logic [AW:0]  rdPtr;
  wire          empty = (wrPtr == rdPtr);
  wire          full  = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  wire          push  = inValid && !full;
  wire          pop   = outPort.ready && !empty;

  // full is exact, so the pixel side stalling backs the source up
  assign inReady       = !full;
  assign outPort.valid = !empty;
  assign outPort.data  = mem[rdPtr[AW-1:0]];

  // storage has no reset, only pointers carry state
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wrPtr[AW-1:0]] <= inData;
  end

  // pointers with one wrap bit
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      if (push)
        wrPtr <= wrPtr + 1'b1;
      if (pop)
        rdPtr <= rdPtr + 1'b1;
    end
  end
endmodule : diwc_fifo

// ### rtl/diwc_top.sv
// Added by the designer: the strobed register port and the register addresses.
module diwc_top #(
  parameter int PW    = diwc_pkg::PIX_W,
  parameter int DEPTH = diwc_pkg::FIFO_DEPTH
) (
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  // register port
  input  wire logic [diwc_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [diwc_pkg::REG_W-1:0]  regWrData,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output      logic [diwc_pkg::REG_W-1:0]  regRdData,
  // frame timing from the display timing logic, same clock
  input  wire logic                        pixelEn,
  input  wire logic                        fieldTwo,
  input  wire logic                        activeLine,
  input  wire logic                        activePixel,
  input  wire logic [diwc_pkg::CNT_W-1:0]  frameLine,
  input  wire logic [diwc_pkg::CNT_W-1:0]  framePixel,
  // pixel source into the display fifo
  input  wire logic                        srcValid,
  input  wire logic [PW-1:0]               srcData,
  output      logic                        srcReady,
  // video sink
  output      logic                        vidValid,
  output      logic [PW-1:0]               vidData,
  output      logic                        vidImage
);
  import diwc_pkg::*;

  logic [REG_W-1:0] field1ImageSize;
  logic [REG_W-1:0] field2ImageOffset;
  logic [REG_W-1:0] ctrlReg;
  logic [REG_W-1:0] timingReg;
  logic [CNT_W-1:0] imageLineCounter;
  logic [CNT_W-1:0] imagePixelCounter;
  logic             pixRun;
  logic             prevField;
  logic             prevActive;

  diwc_stream_if #(.W(PW)) pixQ ();

  diwc_fifo #(
    .W     (PW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk    (mclk),
    .rstn    (rstn),
    .inValid (srcValid),
    .inData  (srcData),
    .inReady (srcReady),
    .outPort (pixQ.src)
  );

  // lsb forced low for the interleaved modes, where pixels go in pairs
  function automatic logic [CNT_W-1:0] evenIf(input logic [CNT_W-1:0] v, input logic force0);
    evenIf = force0 ? {v[CNT_W-1:1], 1'b0} : v;
  endfunction : evenIf

  // register fields
  wire diwc_mode_e       mode       = diwc_mode_e'(ctrlReg[MODE_LSB +: MODE_W]);
  wire                   rawMode    = (mode == DIWC_RAW);
  wire [CNT_W-1:0]       field1_image_height = field1ImageSize[HI_LSB +: CNT_W]; // R3
  wire [CNT_W-1:0]       field1_image_width  =
    evenIf(field1ImageSize[LO_LSB +: CNT_W], !rawMode); // R4
  wire [CNT_W-1:0]       field2_vertical_offset = field2ImageOffset[HI_LSB +: CNT_W]; // R16
  wire [CNT_W-1:0]       field2_horizontal_offset =
    evenIf(field2ImageOffset[LO_LSB +: CNT_W], !rawMode); // R17
  wire                   negVert    = field2ImageOffset[NV_BIT] && !rawMode; // R14
  wire                   negHorz    = field2ImageOffset[NH_BIT] && !rawMode; // R15
  wire [CNT_W-1:0]       field2_vblank_end_line = timingReg[HI_LSB +: CNT_W];
  wire [CNT_W-1:0]       frame_width = timingReg[LO_LSB +: CNT_W];

  // field 2 first image line; a negative offset reaches into vertical blanking
  wire [CNT_W-1:0] f2LoadLine = negVert
    ? field2_vblank_end_line - field2_vertical_offset  // R7
    : field2_vblank_end_line + field2_vertical_offset; // R6
  // field 2 line image start; a negative offset reaches into horizontal blanking
  wire [CNT_W-1:0] f2StartPix = negHorz
    ? frame_width - field2_horizontal_offset // R13
    : field2_horizontal_offset;              // R12
  wire [CNT_W-1:0] startPix   = fieldTwo ? f2StartPix : CNT_ZERO;

  // frame events qualified by the pixel enable, except the active end edge lineActEnd
  wire lineStart   = pixelEn && (framePixel == CNT_ZERO);
  wire fieldChange = pixelEn && (fieldTwo != prevField);
  wire lineActEnd  = prevActive && !activePixel;
  wire f1Load      = !fieldTwo && lineStart && activeLine && (imageLineCounter == CNT_ZERO);
  wire f2Load      = fieldTwo && lineStart && (frameLine == f2LoadLine) &&
                     (imageLineCounter == CNT_ZERO); // R6 R7
  wire lineLoad    = f1Load || f2Load;
  wire lineStep    = lineStart && (imageLineCounter != CNT_ZERO) &&
                     (imageLineCounter != CNT_MAX);

  // counter value as seen by this pixel, so the load line already counts as one
  wire [CNT_W-1:0] curLine = lineLoad ? CNT_ONE :
                             lineStep ? imageLineCounter + CNT_ONE : imageLineCounter;
  // vertical window: field 1 ends past its height, field 2 runs to field end;
  // the field change pixel still carries the old field's count, so it never opens
  wire vWin = !fieldChange && (curLine != CNT_ZERO) &&
              (fieldTwo || (curLine <= field1_image_height)); // R2 R8

  // horizontal window
  wire             hStart  = pixelEn && vWin && (framePixel == startPix); // R12 R13
  wire [CNT_W-1:0] curPix  = hStart ? CNT_ZERO : imagePixelCounter;       // R11
  wire             inLine  = hStart || pixRun;
  wire             f1Full  = !fieldTwo && (curPix == field1_image_width);  // R1
  wire             f2End   = fieldTwo && pixRun && !hStart && lineActEnd;
  wire             emitNow = pixelEn && inLine && !f1Full && !f2End;      // R18

  // pop only when a pixel really leaves; an empty fifo shows as blank
  assign pixQ.ready = emitNow;
  wire             gotPix  = emitNow && pixQ.valid;
  wire [PW-1:0]    nextVid = gotPix ? pixQ.data : BLANK_VALUE[PW-1:0];

  // field and active edge trackers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      prevField  <= 1'b0;
      prevActive <= 1'b0;
    end
    else if (pixelEn)
    begin
      prevField  <= fieldTwo;
      prevActive <= activePixel;
    end
  end

  // image line counter, cleared at every field boundary
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      imageLineCounter <= CNT_ZERO;
    else if (fieldChange)
      imageLineCounter <= CNT_ZERO;
    else if (lineLoad)
      imageLineCounter <= CNT_ONE; // R6 R7
    else if (lineStep)
      imageLineCounter <= imageLineCounter + CNT_ONE; // R18
  end

  // image pixel counter and line run flag
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      imagePixelCounter <= CNT_ZERO;
      pixRun            <= 1'b0;
    end
    else if (fieldChange)
    begin
      imagePixelCounter <= CNT_ZERO;
      pixRun            <= 1'b0;
    end
    else if (pixelEn && inLine)
    begin
      imagePixelCounter <= emitNow ? curPix + CNT_ONE : curPix; // R11
      pixRun            <= emitNow; // R1
    end
  end

  // output stage, registered; blank value fills the window outside the image
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      vidValid <= 1'b0;
      vidData  <= BLANK_VALUE[PW-1:0];
      vidImage <= 1'b0;
    end
    else
    begin
      vidValid <= pixelEn;
      if (pixelEn)
      begin
        vidData  <= nextVid; // R1 R2 R8 R12
        vidImage <= gotPix;
      end
    end
  end

  // register write decode
  wire wrF1   = regWr && (regAddr == REG_F1_SIZE);
  wire wrF2   = regWr && (regAddr == REG_F2_OFF);
  wire wrCtrl = regWr && (regAddr == REG_CTRL);
  wire wrTim  = regWr && (regAddr == REG_TIMING);

  // registers keep only writable bits, so reserved bits stay zero
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      field1ImageSize   <= REG_RESET;
      field2ImageOffset <= REG_RESET;
      ctrlReg           <= REG_RESET;
      timingReg         <= REG_RESET;
    end
    else
    begin
      if (wrF1)
        field1ImageSize <= regWrData & F1_SIZE_MASK; // R3 R5
      if (wrF2)
        field2ImageOffset <= regWrData & F2_OFF_MASK; // R5 R16
      if (wrCtrl)
        ctrlReg <= regWrData & CTRL_MASK;
      if (wrTim)
        timingReg <= regWrData & TIMING_MASK;
    end
  end

  // status shows the live counters and the line run flag
  wire [REG_W-1:0] statusWord;
  assign statusWord = (REG_RESET | ({20'h00000, imageLineCounter} << HI_LSB) |
                       {20'h00000, imagePixelCounter}) |
                      ({31'h00000000, pixRun} << RUN_BIT);

  // read select; unmapped addresses read zero
  wire [REG_W-1:0] rdSel =
    (regAddr == REG_F1_SIZE) ? field1ImageSize :
    (regAddr == REG_F2_OFF)  ? field2ImageOffset :
    (regAddr == REG_CTRL)    ? ctrlReg :
    (regAddr == REG_TIMING)  ? timingReg :
    (regAddr == REG_STATUS)  ? statusWord : REG_RESET;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      regRdData <= REG_RESET;
    else if (regRd)
      regRdData <= rdSel; // R5
    else
      regRdData <= REG_RESET;
  end
endmodule : diwc_top

// ### tb/diwc_monitor.sv
module diwc_monitor
  import diwc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdData,
  input wire logic        pixelEn,
  input wire logic        fieldTwo,
  input wire logic        activeLine,
  input wire logic [11:0] framePixel,
  input wire logic        vidValid,
  input wire logic [9:0]  vidData,
  input wire logic        vidImage
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] f1;
  logic [31:0] f2;
  logic [1:0]  md;
  // shadow copies, so window edges are known without peeking inside
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      f1 <= '0;
      f2 <= '0;
      md <= '0;
    end
    else if (regWr)
    begin
      if (regAddr == REG_F1_SIZE) f1 <= regWrData;
      if (regAddr == REG_F2_OFF) f2 <= regWrData;
      if (regAddr == REG_CTRL) md <= regWrData[1:0];
    end
  // lsb only counts in raw mode
  wire         raw  = md == DIWC_RAW;
  wire  [11:0] wEff = raw ? f1[11:0] : {f1[11:1], 1'b0};
  wire  [11:0] hEff = raw ? f2[11:0] : {f2[11:1], 1'b0};
  wire         nhOn = f2[15] && !raw;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  sequence s_rd_f1;
    regRd && regAddr == REG_F1_SIZE;
  endsequence
  sequence s_rd_f2;
    regRd && regAddr == REG_F2_OFF;
  endsequence
  property p_rd_idle;
    !regRd |=> regRdData == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero when idle");
  property p_resv1;
    s_rd_f1 |=> (regRdData & ~F1_SIZE_MASK) == '0;
  endproperty
  a_resv1: assert property (p_resv1)
    else $error("size register reserved bits set");
  property p_resv2;
    s_rd_f2 |=> (regRdData & ~F2_OFF_MASK) == '0;
  endproperty
  a_resv2: assert property (p_resv2)
    else $error("offset register reserved bits set");
  property p_valid;
    1'b1 |=> vidValid == $past(pixelEn);
  endproperty
  a_valid: assert property (p_valid)
    else $error("output strobe not one cycle after pixel enable");
  property p_hold;
    !pixelEn |=> $stable(vidData) && $stable(vidImage);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pixel output moved without pixel enable");
  property p_blank;
    vidValid && !vidImage |-> vidData == BLANK_VALUE;
  endproperty
  a_blank: assert property (p_blank)
    else $error("non image pixel not blank");
  property p_f1_wid;
    pixelEn && !fieldTwo && framePixel >= wEff |=> !vidImage;
  endproperty
  a_f1_wid: assert property (p_f1_wid)
    else $error("field one image past its width");
  property p_f1_line;
    pixelEn && !fieldTwo && !activeLine |=> !vidImage;
  endproperty
  a_f1_line: assert property (p_f1_line)
    else $error("field one image on inactive line");
  property p_f2_hoff;
    pixelEn && fieldTwo && !nhOn && framePixel < hEff |=> !vidImage;
  endproperty
  a_f2_hoff: assert property (p_f2_hoff)
    else $error("field two image before its offset");
endmodule : diwc_monitor

bind diwc_top diwc_monitor mon_u
(
  .mclk, .rstn, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .pixelEn,
  .fieldTwo, .activeLine, .framePixel, .vidValid, .vidData, .vidImage
);

// ### tb/diwc_sink_model.sv
module diwc_sink_model
(
  input wire logic mclk,
  input wire logic vidValid,
  input wire logic vidImage,
  output     int   imgCount
);
  timeunit 1ns;
  timeprecision 1ps;
  // a video sink cannot stall, so it only tallies delivered image pixels
  initial imgCount = 0;
  // sampled mid-cycle, where the registered outputs have settled
  always @(negedge mclk)
    if (vidValid === 1'b1 && vidImage === 1'b1)
      imgCount++;
endmodule : diwc_sink_model

// ### tb/testbench.sv
`define CHK(nm, ex, gt) \
  begin \
    num_checks++; \
    if ((gt) !== (ex)) \
    begin \
      err_count++; \
      $display("ERROR %s exp %h got %h", nm, ex, gt); \
    end \
  end

module testbench;
  import diwc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rstn, regWr, regRd, pixelEn, fieldTwo, activeLine, activePixel;
  logic        srcValid, srcReady, vidValid, vidImage;
  logic [7:0]  regAddr;
  logic [31:0] regWrData, regRdData, seed;
  logic [11:0] frameLine, framePixel;
  logic [9:0]  srcData, vidData, fifoQ[$];
  logic [10:0] expQ[$], expv;
  int          err_count, num_checks, imgCount;

  diwc_top dut_u
  (
    .mclk, .rstn, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .pixelEn,
    .fieldTwo, .activeLine, .activePixel, .frameLine, .framePixel, .srcValid,
    .srcData, .srcReady, .vidValid, .vidData, .vidImage
  );
  diwc_sink_model sink_u (.mclk, .vidValid, .vidImage, .imgCount);

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic stop_test;
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    `CHK("regRdData", e, regRdData)
  endtask : rd

  // fill to the brim, then offer one more word that must be refused
  task automatic fill;
    repeat (32)
    begin
      @(posedge mclk);
      seed = lfsr(seed);
      srcValid <= 1'b1;
      srcData  <= seed[9:0];
      fifoQ.push_back(seed[9:0]);
    end
    @(posedge mclk);
    srcData <= ~seed[9:0];
    @(negedge mclk);
    `CHK("srcReady", 1'b0, srcReady)
    @(posedge mclk);
    srcValid <= 1'b0;
  endtask : fill

  // one pixel slot; an empty fifo inside the window yields blank
  task automatic pix(input logic f2, al, ap, input logic [11:0] ln, px, input logic img);
    @(posedge mclk);
    pixelEn     <= 1'b1;
    fieldTwo    <= f2;
    activeLine  <= al;
    activePixel <= ap;
    frameLine   <= ln;
    framePixel  <= px;
    if (img && fifoQ.size() > 0)
      expQ.push_back({1'b1, fifoQ.pop_front()});
    else
      expQ.push_back({1'b0, BLANK_VALUE});
  endtask : pix

  // lines of 8 active pixels plus one blanking slot, window [x0,x1) x [y0,y1)
  task automatic frame(input logic f2, input int l0, l1, y0, y1, x0, x1);
    for (int ln = l0; ln <= l1; ln++)
      for (int p = 0; p < 9; p++)
        pix(f2, ln > l0, p < 8, 12'(ln), 12'(p),
            p < 8 && ln >= y0 && ln < y1 && p >= x0 && p < x1);
    @(posedge mclk);
    pixelEn <= 1'b0;
  endtask : frame

  // compare each delivered pixel with the oldest note, mid-cycle where it has settled
  always @(negedge mclk)
    if (vidValid === 1'b1)
    begin
      expv = expQ.size() > 0 ? expQ.pop_front() : 11'hx;
      `CHK("pixel", expv, {vidImage, vidData})
    end

  initial
  begin
    {regWr, regRd, pixelEn, fieldTwo, activeLine, activePixel, srcValid, rstn} = '0;
    {regAddr, regWrData, frameLine, framePixel, srcData} = '0;
    seed = 32'h3cd7cd47;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd(REG_F1_SIZE, 32'h0);
    rd(REG_F2_OFF, 32'h0);
    wr(REG_F1_SIZE, 32'hffff_ffff);
    rd(REG_F1_SIZE, 32'h0fff_0fff);
    seed = lfsr(seed);
    wr(REG_F2_OFF, seed);
    rd(REG_F2_OFF, seed & 32'h8fff_8fff);
    rd(8'h14, 32'h0);
    fill();
    wr(REG_F1_SIZE, 32'h0002_0005);
    frame(1'b0, 0, 4, 1, 3, 0, 4);
    wr(REG_TIMING, 32'h000a_0009);
    wr(REG_F2_OFF, 32'h0002_0003);
    frame(1'b1, 10, 13, 12, 99, 2, 8);
    frame(1'b0, 0, 0, 0, 0, 0, 0);
    wr(REG_F2_OFF, 32'h8002_0002);
    frame(1'b1, 7, 10, 8, 99, 2, 8);
    fill();
    wr(REG_CTRL, 32'h0000_0002);
    rd(REG_CTRL, 32'h0000_0002);
    wr(REG_F1_SIZE, 32'h0001_0003);
    frame(1'b0, 0, 1, 1, 2, 0, 3);
    rd(REG_STATUS, 32'h0001_0003);
    repeat (2) @(posedge mclk);
    `CHK("imgCount", 35, imgCount)
    `CHK("srcReady", 1'b1, srcReady)
    `CHK("expQ", 0, expQ.size())
    stop_test();
  end
endmodule : testbench
